// ===== hw/chain_head.sv
// Chain head teach-in, count check, slot store and mode LED
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - No stored configuration: red blink at 1 Hz
// - Wiring teach-in only without IO-Link session
// - Both inputs second output: teach, red/green
// - After successful store: green blink 1 Hz
// - Every power-up without teach-in compares node count to taught
// - New teach-in fully replaces old configuration
// - Teach without terminator erases configuration
// - Terminator-only teach disables count, type checks
// - Type check only in controller-configured variant
// - At most 32 nodes in one chain
// - Positions start after head, end at terminator
// - One slot per position, 01 to 33
// - Slot holds node type, terminator or empty
// - Factory default: node at one, terminator two
// - IO-Link at lowest speed, 4.8 kBaud
module chain_head #(
	parameter int unsigned HALF_CYCLES = chain_head_pkg::HALF_PERIOD,
	parameter int unsigned SETTLE      = 16
) (
	input  wire logic                     clk,
	input  wire logic                     srst,
	input  wire logic                     first_chain_input,
	input  wire logic                     second_chain_input,
	input  wire logic                     first_test_output,
	input  wire logic                     second_test_output,
	input  wire logic                     iolink_session,
	input  wire chain_head_pkg::scan_t    scan,
	input  wire chain_head_pkg::slot_wr_t slot_wr,
	input  wire logic                     slot_store,
	output logic                          led_red,
	output logic                          led_green,
	output logic                          chain_ok,
	output logic                          chain_fault,
	output logic                          count_check_on,
	output logic                          type_check_on,
	output logic [5:0]                    taught_count,
	output logic                          baud_tick
);

	initial begin
		if (HALF_CYCLES < 2 || SETTLE < 2 || SETTLE > 255) $error("chain_head: bad parameter");
	end

	typedef enum logic [6:0] {
		ST_SETTLE  = 7'h01,
		ST_DECIDE  = 7'h02,
		ST_TEACH   = 7'h04,
		ST_STORED  = 7'h08,
		ST_CHECK   = 7'h10,
		ST_RUN     = 7'h20,
		ST_FAULT   = 7'h40
	} state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	always_ff @(posedge clk) begin
		meta_q <= {first_chain_input, second_chain_input, first_test_output, second_test_output};
		sync_q <= meta_q;
	end

	logic a_in;
	logic b_in;
	logic x1_in;
	logic x2_in;
	assign a_in  = sync_q[3];
	assign b_in  = sync_q[2];
	assign x1_in = sync_q[1];
	assign x2_in = sync_q[0];

	////////////////////////////////////////////////////////////////////////////////
	// Stored configuration (kept across power-up in the real part)
	logic [3:0] slot_q [chain_head_pkg::SLOT_COUNT];
	logic       cfg_valid_q;
	logic [5:0] count_q;
	logic       ign_count_q;
	logic       ign_type_q;
	logic       ctrl_cfg_q;

	state_t     state_q;
	logic [7:0] settle_q;
	logic       teach_q;
	logic       teach_ok_q;
	logic       store_now;
	logic       erase_now;
	logic       term_only;
	logic       teach_end;
	logic       boot_q;
	logic       has_term;
	logic [5:0] last_node;

	// Wiring teach result from the scan
	assign store_now = (state_q == ST_TEACH) && scan.valid && scan.term_seen
		&& (scan.count <= 6'(chain_head_pkg::MAX_NODES));
	assign erase_now = (state_q == ST_TEACH) && scan.valid && !scan.term_seen;
	assign term_only = scan.count == 6'h00;
	assign teach_end = store_now || erase_now;

	// Configuration words
	always_ff @(posedge clk) begin
		if (boot_q) begin
			// Blank memory: factory state asks for configuration
			cfg_valid_q <= 1'b0;
			count_q     <= 6'h00;
			ign_count_q <= 1'b0;
			ign_type_q  <= 1'b1;
			ctrl_cfg_q  <= 1'b0;
		end else if (store_now) begin
			cfg_valid_q <= 1'b1;
			count_q     <= scan.count;
			ign_count_q <= term_only;
			ign_type_q  <= 1'b1;
			ctrl_cfg_q  <= 1'b0;
		end else if (erase_now) begin
			cfg_valid_q <= 1'b0;
			count_q     <= 6'h00;
			ign_count_q <= 1'b0;
			ign_type_q  <= 1'b1;
			ctrl_cfg_q  <= 1'b0;
		end else if (slot_store && iolink_session) begin
			cfg_valid_q <= 1'b1;
			count_q     <= last_node;
			ign_count_q <= 1'b0;
			ign_type_q  <= 1'b0;
			ctrl_cfg_q  <= 1'b1;
		end
	end

	// Slot table, factory default after first power-up
	// Lowest terminator slot gives the node count; none found means blank memory
	always_comb begin
		last_node = 6'h00;
		has_term  = 1'b0;
		for (int i = chain_head_pkg::SLOT_COUNT - 1; i >= 0; i--) begin
			if (slot_q[i] == chain_head_pkg::TYPE_TERMINATOR) begin
				last_node = 6'(i);
				has_term  = 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < chain_head_pkg::SLOT_COUNT; g++) begin : gen_slot
			always_ff @(posedge clk) begin
				if (boot_q) begin
					slot_q[g] <= (g == 0) ? chain_head_pkg::DEFAULT_POS1
						: (g == 1) ? chain_head_pkg::TYPE_TERMINATOR : chain_head_pkg::TYPE_EMPTY;
				end else if (slot_wr.valid && iolink_session && slot_wr.index == 6'(g + 1)) begin
					slot_q[g] <= slot_wr.kind;
				end
			end
		end
	endgenerate

	// Factory load requested while in reset and no terminator slot is held
	always_ff @(posedge clk) begin
		boot_q <= srst && !has_term;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q    <= ST_SETTLE;
			settle_q   <= 8'(SETTLE);
			teach_q    <= 1'b0;
			teach_ok_q <= 1'b0;
		end else begin
			case (state_q)
				ST_SETTLE: begin
					settle_q <= settle_q - 8'h01;
					if (settle_q == 8'h01) begin
						state_q <= ST_DECIDE;
					end
				end
				ST_DECIDE: begin
					// Sampled once; later rewiring waits for the next power-up
					if (a_in == x2_in && b_in == x2_in && a_in != x1_in && !iolink_session) begin
						teach_q <= 1'b1;
						state_q <= ST_TEACH;
					end else begin
						state_q <= ST_CHECK;
					end
				end
				ST_TEACH: begin
					if (store_now) begin
						teach_ok_q <= 1'b1;
						state_q    <= ST_STORED;
					end else if (erase_now) begin
						state_q <= ST_STORED;
					end
				end
				ST_STORED: begin
					state_q <= ST_STORED;
				end
				ST_CHECK: begin
					if (scan.valid) begin
						if (!cfg_valid_q || ign_count_q || scan.count == count_q) begin
							state_q <= ST_RUN;
						end else begin
							state_q <= ST_FAULT;
						end
					end
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
				ST_FAULT: begin
					state_q <= ST_FAULT;
				end
				default: begin
					state_q <= ST_SETTLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Blink and baud dividers
	logic [31:0] blink_cnt_q;
	logic        phase_q;
	logic [15:0] baud_cnt_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			blink_cnt_q <= 32'h0000_0000;
			phase_q     <= 1'b0;
		end else if (teach_end) begin
			// Restart so the blink after teach-in opens on a full lit phase
			blink_cnt_q <= 32'h0000_0000;
			phase_q     <= 1'b1;
		end else if (blink_cnt_q == 32'(HALF_CYCLES - 1)) begin
			blink_cnt_q <= 32'h0000_0000;
			phase_q     <= ~phase_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	// Bit-rate enable for the IO-Link line at COM1
	always_ff @(posedge clk) begin
		if (srst) begin
			baud_cnt_q <= 16'h0000;
			baud_tick  <= 1'b0;
		end else if (baud_cnt_q == 16'(chain_head_pkg::BIT_CYCLES - 1)) begin
			baud_cnt_q <= 16'h0000;
			baud_tick  <= 1'b1;
		end else begin
			baud_cnt_q <= baud_cnt_q + 16'h0001;
			baud_tick  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operating-mode LED and status outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			led_red   <= 1'b0;
			led_green <= 1'b0;
		end else if (state_q == ST_TEACH) begin
			led_red   <= phase_q;
			led_green <= ~phase_q;
		end else if (state_q == ST_STORED && teach_ok_q) begin
			led_red   <= 1'b0;
			led_green <= phase_q;
		end else if (!cfg_valid_q) begin
			led_red   <= phase_q;
			led_green <= 1'b0;
		end else if (state_q == ST_FAULT) begin
			led_red   <= 1'b1;
			led_green <= 1'b0;
		end else begin
			led_red   <= 1'b0;
			led_green <= state_q == ST_RUN;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			chain_ok       <= 1'b0;
			chain_fault    <= 1'b0;
			count_check_on <= 1'b0;
			type_check_on  <= 1'b0;
			taught_count   <= 6'h00;
		end else begin
			chain_ok       <= state_q == ST_RUN && cfg_valid_q;
			chain_fault    <= state_q == ST_FAULT;
			count_check_on <= cfg_valid_q && !ign_count_q;
			type_check_on  <= cfg_valid_q && ctrl_cfg_q && !ign_type_q;
			taught_count   <= count_q;
		end
	end

endmodule
`default_nettype wire

// ===== hw/chain_head_pkg.sv
// Package of constants and types for the series chain head checker
package chain_head_pkg;
	localparam int unsigned MAX_NODES      = 32;
	localparam int unsigned SLOT_COUNT     = 33;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned BLINK_HZ       = 1;
	localparam int unsigned HALF_PERIOD    = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned IOLINK_BAUD    = 4800;
	localparam int unsigned BIT_CYCLES     = CLK_HZ / IOLINK_BAUD;
	localparam int unsigned ALT_HALF       = HALF_PERIOD / 2;

	// Position slot type codes
	typedef enum logic [3:0] {
		TYPE_EMPTY      = 4'h0,
		TYPE_TERMINATOR = 4'hF,
		TYPE_NODE_A     = 4'h1
	} slot_type_t;

	localparam logic [3:0] DEFAULT_POS1 = 4'h1;

	// LED drive
	typedef struct packed {
		logic red;
		logic green;
	} led_t;

	// Slot write from the IO-Link parameter path
	typedef struct packed {
		logic       valid;
		logic [5:0] index;
		logic [3:0] kind;
	} slot_wr_t;

	// Chain scan result
	typedef struct packed {
		logic       valid;
		logic       term_seen;
		logic [5:0] count;
	} scan_t;
endpackage

// ===== tb/chain_head_asserts.sv
// Port assertions for the chain head
`timescale 1ns/1ps
`default_nettype none
module chain_head_asserts #(
	parameter int unsigned HALF_CYCLES = 8
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       led_red,
	input wire logic       led_green,
	input wire logic       chain_ok,
	input wire logic       chain_fault,
	input wire logic       count_check_on,
	input wire logic       type_check_on,
	input wire logic [5:0] taught_count,
	input wire logic       baud_tick
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [31:0] dk_q;
	logic [31:0] run_q;
	logic [1:0]  col_q;
	logic        lit_q;
	// Dark length, last lit colour and length of its lit run
	always_ff @(posedge clk) begin
		if (srst) begin
			dk_q  <= 32'h0000_0000;
			run_q <= 32'h0000_0000;
			col_q <= 2'h0;
			lit_q <= 1'b0;
		end else if (led_red || led_green) begin
			dk_q  <= 32'h0000_0000;
			run_q <= ({led_red, led_green} == col_q && dk_q == 32'h0000_0000) ? run_q + 32'h0000_0001 : 32'h0000_0001;
			col_q <= {led_red, led_green};
			lit_q <= 1'b1;
		end else begin
			dk_q <= dk_q + 32'h0000_0001;
		end
	end
	////////////////////////////////////////
	property p_rst;
		disable iff (1'b0) srst |=> !led_red && !led_green && !chain_ok && !chain_fault && !baud_tick;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_excl;
		!(chain_ok && chain_fault);
	endproperty
	a_excl: assert property (p_excl) else $error("ok and fault together");
	property p_led;
		!(led_red && led_green);
	endproperty
	a_led: assert property (p_led) else $error("both colours lit");
	property p_tick;
		baud_tick |=> !baud_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick too long");
	property p_dark;
		lit_q && dk_q != 0 && (led_red || led_green) && {led_red, led_green} == col_q && run_q == HALF_CYCLES
			|-> dk_q == HALF_CYCLES;
	endproperty
	a_dark: assert property (p_dark) else $error("blink off phase wrong");
	property p_chk;
		!count_check_on |-> !type_check_on && !chain_fault;
	endproperty
	a_chk: assert property (p_chk) else $error("check active while off");
	property p_max;
		taught_count <= 6'h20;
	endproperty
	a_max: assert property (p_max) else $error("count above limit");
	property p_stand;
		(chain_ok || chain_fault) |=> $stable({chain_ok, chain_fault});
	endproperty
	a_stand: assert property (p_stand) else $error("status changed");
endmodule
`default_nettype wire

// ===== tb/chain_head_tb.sv
// Self-checking bench for the chain head
`timescale 1ns/1ps
`default_nettype none
module chain_head_tb;
	typedef struct packed {
		logic [2:0] m;
		logic [5:0] n;
		logic [5:0] t;
		logic [1:0] cf;
	} row_t;
	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  teach = 1'b0;
	logic                  sess = 1'b0;
	logic                  pr;
	chain_head_pkg::scan_t scan = '0;
	logic                  first_test_output, second_test_output, first_chain_input, second_chain_input;
	logic                  led_red, led_green, chain_ok, chain_fault, count_check_on, type_check_on, baud_tick;
	logic [5:0]            taught_count;
	int                    fails = 0;
	int                    num_checks = 0;
	int                    i;
	row_t                  rows [8] = '{'{3'h5, 6'h05, 6'h05, 2'h2}, '{3'h1, 6'h05, 6'h05, 2'h2},
		'{3'h1, 6'h04, 6'h05, 2'h3}, '{3'h7, 6'h09, 6'h05, 2'h3}, '{3'h5, 6'h20, 6'h20, 2'h2},
		'{3'h1, 6'h20, 6'h20, 2'h2}, '{3'h5, 6'h00, 6'h00, 2'h0}, '{3'h1, 6'h03, 6'h00, 2'h0}};
	// Clock
	always #5 clk = ~clk;
	chain_partner u_partner (.teach, .t1(first_test_output), .t2(second_test_output), .a(first_chain_input),
		.b(second_chain_input));
	chain_head #(.HALF_CYCLES(8)) uut (.clk, .srst, .first_chain_input, .second_chain_input, .first_test_output,
		.second_test_output, .iolink_session(sess), .scan, .slot_wr('0), .slot_store(1'b0), .led_red, .led_green,
		.chain_ok, .chain_fault, .count_check_on, .type_check_on, .taught_count, .baud_tick);
	////////////////////////////////////////
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo(int lim);
		if (i >= lim) begin
			fails++;
			print_verdict();
		end
	endtask
	// One power-up: reset, wiring decision, one scan result
	task automatic pu(row_t r, logic rw);
		logic tr;
		tr = r.m[2] & ~r.m[1] & ~rw;
		teach <= r.m[2];
		sess <= r.m[1];
		srst <= 1'b1;
		repeat (20) @(posedge clk);
		chk({led_red, led_green, chain_ok, taught_count}, 16'h0000);
		srst <= 1'b0;
		repeat (20) @(posedge clk);
		teach <= r.m[2] | rw;
		scan <= {1'b1, r.m[0], r.n};
		@(posedge clk);
		scan <= '0;
		if (r.m[0]) begin
			for (i = 0; i < 300; i++) begin
				if (tr ? {taught_count, count_check_on} === {r.t, r.cf[1]} : (chain_ok | chain_fault) === 1'b1) break;
				@(posedge clk);
			end
			tmo(300);
			chk({taught_count, count_check_on, chain_fault & ~tr}, {r.t, r.cf[1], r.cf[0] & ~tr});
			if (tr) begin
				for (i = 0; i < 20 && led_green !== 1'b1; i++) @(posedge clk);
				tmo(20);
				chk({led_red, led_green}, 16'h0001);
			end
		end
	endtask
	////////////////////////////////////////
	initial begin
		for (int k = 0; k < 8; k++) pu(rows[k], 1'b0);
		pu('{3'h5, 6'h06, 6'h06, 2'h2}, 1'b0);
		pu('{3'h1, 6'h02, 6'h06, 2'h3}, 1'b1);
		pu('{3'h4, 6'h04, 6'h00, 2'h0}, 1'b0);
		pr = 1'b0;
		for (i = 0; i < 300 && !(pr && !led_red && !led_green); i++) begin
			pr = led_red;
			@(posedge clk);
		end
		tmo(300);
		chk({count_check_on, type_check_on, chain_ok}, 16'h0000);
		for (i = 0; i < 21000 && baud_tick !== 1'b1; i++) @(posedge clk);
		tmo(21000);
		@(posedge clk);
		for (i = 1; i < 21000 && baud_tick !== 1'b1; i++) @(posedge clk);
		chk(i[15:0], 16'h5161);
		print_verdict();
	end
endmodule
bind chain_head chain_head_asserts #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.clk, .srst, .led_red, .led_green, .chain_ok,
	.chain_fault, .count_check_on, .type_check_on, .taught_count, .baud_tick);
`default_nettype wire

// ===== tb/chain_partner.sv
// Controller test outputs and chain wiring
`timescale 1ns/1ps
`default_nettype none
module chain_partner (
	input  wire logic teach,
	output logic      t1,
	output logic      t2,
	output logic      a,
	output logic      b
);
	// Test outputs at distinct levels; teach wiring feeds the second to both
	assign t1 = 1'b1;
	assign t2 = 1'b0;
	assign a = teach ? t2 : t1;
	assign b = t2;
	// Link model carries no timestamps
endmodule
`default_nettype wire
